// [rtl/gls_pkg.sv]
// Constants, field layouts and carrier types for the guard-lock safety controller.
// Assumes one 20 MHz clock and APB register access with 32-bit data.
// Functional notes
// (R01) Power-to-unlock variant: asserted lock command releases the lock.
// (R02) Power-to-lock variant: asserted lock command engages the lock.
// (R03) Lock-monitored variant: unlocking drops outputs; relocking with actuator re-enables.
// (R04) Door-monitored variant: only opening the guard drops the outputs.
// (R05) Recoverable fault while enabled: warning, diag low, outputs off after 30 min.
// (R06) Latched error clears on guard opening once its cause is gone.
// (R07) Remote controller may clear a latched fault with the serial reset bit.
// (R08) Serial reset acts on a one-to-zero fall, cause removed.
// (R09) More than one output fault locks out until a power cycle.
// (R10) Internal faults drop the outputs at once.
// (R11) A warning clears by itself when its cause disappears.
// (R12) Teach-in: green off, red on, yellow 1 Hz, all outputs low.
// (R13) Ten seconds into teach-in yellow turns to short 3 Hz flashes.
// (R14) No power-down within five minutes aborts with five red flashes.
// (R15) Learned code becomes active only when redetected after power cycle; also committed on redetection after a teach-in abort.
// (R16) One-time variant refuses further teach-ins once learned.
// (R17) Re-teachable variant: unlimited teach-ins, new code voids old one.
// (R18) After re-teach, ten-minute enable inhibit with green flashing.
// (R19) Power loss during the inhibit restarts it from zero.
// (R20) Intermediate knob prevents locking and is an immediate six-flash fault.
// (R21) Closed and locked: green and yellow on, red off, outputs high.
// (R22) Closed, unlocked: yellow flashes; diag high if unlock commanded.
// (R23) Guard open: green only, safety and diag outputs low.
// (R24) Red flashes one to four for output, cross-short, temperature warnings.
// (R25) Five red flashes for actuator fault, continuous red for internal defect.
// (R26) Intervals and flash rates come from a prescaler; warning timer clears.
package gls_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_HZ = 12;
   localparam int TICK_CYC = CLK_HZ / TICK_HZ;
   localparam int WARN_MIN = 30;
   localparam int INHIB_MIN = 10;
   localparam int ABORT_MIN = 5;
   localparam int TEACH_SEC = 10;
   localparam logic [14:0] WARN_TICKS = 15'(WARN_MIN * 60 * TICK_HZ);
   localparam logic [14:0] INHIB_TICKS = 15'(INHIB_MIN * 60 * TICK_HZ);
   localparam logic [14:0] ABORT_TICKS = 15'(ABORT_MIN * 60 * TICK_HZ);
   localparam logic [14:0] TEACH_TICKS = 15'(TEACH_SEC * TICK_HZ);
   localparam logic [3:0] PHASE_LAST = 4'hB;
   localparam logic [1:0] SLOT_TICKS = 2'h3;

   // ****************************************************************
   // Fault codes, equal to the red pulse count; FC_INTERNAL shows steady red
   // ****************************************************************
   localparam logic [2:0] FC_NONE = 3'h0;
   localparam logic [2:0] FC_OUT_A = 3'h1;
   localparam logic [2:0] FC_OUT_B = 3'h2;
   localparam logic [2:0] FC_XSHORT = 3'h3;
   localparam logic [2:0] FC_TEMP = 3'h4;
   localparam logic [2:0] FC_ACT = 3'h5;
   localparam logic [2:0] FC_KNOB = 3'h6;
   localparam logic [2:0] FC_INTERNAL = 3'h7;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CODE = 8'h08;
   localparam logic [3:0] CTRL_RESET = 4'h2;
   localparam int CTRL_UNLOCK_VAR = 0;
   localparam int CTRL_LOCK_MON = 1;
   localparam int CTRL_INDIV = 2;
   localparam int CTRL_RETEACH = 3;

   typedef struct packed {
      logic lock_cmd;
      logic door_closed;
      logic bolt_in;
      logic knob_mid;
      logic act_present;
      logic [7:0] act_code;
      logic flt_out_a;
      logic flt_out_b;
      logic flt_xshort;
      logic flt_temp;
      logic flt_internal;
      logic diag_rst_req;
   } gls_pins_t;

   typedef enum logic [1:0] {TS_IDLE, TS_LEARN, TS_PWR_REQ, TS_DONE} gls_teach_t;

endpackage

// [rtl/gls_ctrl.sv]
// Guard-lock safety controller: lock magnet, safety outputs, diagnostic output,
// LEDs, delayed shutdown and actuator teach-in, with an APB register slave.
// Assumes RST is the power-on reset and NVM_CLR a factory erase of stored codes.
//
// Chosen here: the register offsets and the APB interface to the registers.
module gls_ctrl #(
   parameter int TICK_CYC = gls_pkg::TICK_CYC
)(
   // Clock, reset, enable
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic NVM_CLR,
   // Pins from the guard and the machine
   input wire logic LOCK_CMD,
   input wire logic DOOR_CLOSED,
   input wire logic BOLT_IN,
   input wire logic KNOB_MID,
   input wire logic ACT_PRESENT,
   input wire logic [7:0] ACT_CODE,
   input wire logic FLT_OUT_A,
   input wire logic FLT_OUT_B,
   input wire logic FLT_XSHORT,
   input wire logic FLT_TEMP,
   input wire logic FLT_INTERNAL,
   input wire logic SERIAL_DIAG_LINK_RESET,
   // Outputs
   output logic MAGNET_ON,
   output logic SAFETY_OUTPUT_A,
   output logic SAFETY_OUTPUT_B,
   output logic DIAG_OUT,
   output logic LED_GREEN,
   output logic LED_RED,
   output logic LED_YELLOW,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);

   if (TICK_CYC < 2) $error("TICK_CYC must be at least 2");

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   localparam int PW = $bits(gls_pkg::gls_pins_t);
   gls_pkg::gls_pins_t pin_raw;
   gls_pkg::gls_pins_t p;
   logic [PW-1:0] sync1;
   assign pin_raw = '{LOCK_CMD, DOOR_CLOSED, BOLT_IN, KNOB_MID, ACT_PRESENT, ACT_CODE, FLT_OUT_A,
                      FLT_OUT_B, FLT_XSHORT, FLT_TEMP, FLT_INTERNAL, SERIAL_DIAG_LINK_RESET};
   // Two stages per pin; the first stage is read only by the second.
   for (genvar i = 0; i < PW; i++)
   begin : g_sync
      always_ff @(posedge REF_CLK)
      begin
         if (RST)
         begin
            sync1[i] <= 1'b0;
            p[i] <= 1'b0;
         end
         else if (CE)
         begin
            sync1[i] <= pin_raw[i];
            p[i] <= sync1[i];
         end
      end
   end

   // ****************************************************************
   // Prescaler and flash patterns
   // ****************************************************************
   logic [31:0] pre;
   logic tick;
   logic [3:0] phase;
   logic [1:0] sub;
   logic [3:0] slot;
   assign tick = (pre == 32'(TICK_CYC - 1));
   // One slow tick per period; all long intervals count these ticks.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         pre <= '0;
         phase <= '0;
         sub <= '0;
         slot <= '0;
      end
      else if (CE)
      begin
         pre <= tick ? '0 : pre + 32'h1; // [R26]
         if (tick)
         begin
            phase <= (phase == gls_pkg::PHASE_LAST) ? 4'h0 : phase + 4'h1;
            sub <= (sub == gls_pkg::SLOT_TICKS - 2'h1) ? 2'h0 : sub + 2'h1;
            if (sub == gls_pkg::SLOT_TICKS - 2'h1)
               slot <= slot + 4'h1;
         end
      end
   end
   logic flash1, flash3;
   assign flash1 = (phase < 4'h6);
   assign flash3 = (phase[1:0] == 2'h0); // [R13]

   // ****************************************************************
   // Configuration register
   // ****************************************************************
   logic [3:0] ctrl;
   logic wr_en, rd_setup, hit;
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign rd_setup = PSEL && !PENABLE;
   assign hit = (PADDR == gls_pkg::OFS_CTRL) || (PADDR == gls_pkg::OFS_STATUS) ||
                (PADDR == gls_pkg::OFS_CODE);
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !hit;
   // Variant selection; meant to be set once before the guard is used.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         ctrl <= gls_pkg::CTRL_RESET;
      else if (CE && wr_en && PADDR == gls_pkg::OFS_CTRL)
         ctrl <= PWDATA[3:0];
   end
   logic unlock_var, lock_mon, indiv, reteach;
   assign unlock_var = ctrl[gls_pkg::CTRL_UNLOCK_VAR];
   assign lock_mon = ctrl[gls_pkg::CTRL_LOCK_MON];
   assign indiv = ctrl[gls_pkg::CTRL_INDIV];
   assign reteach = ctrl[gls_pkg::CTRL_RETEACH];

   // ****************************************************************
   // Retained code store (survives RST, erased by NVM_CLR)
   // ****************************************************************
   logic [7:0] stored_code, pend_code;
   logic learned, pend_valid, inhibit_req;
   logic [14:0] inh_t;
   logic inhibit, first_pres, pres_d, code_ok, redetect;
   gls_pkg::gls_teach_t ts;
   logic [14:0] tt;
   assign redetect = pend_valid && p.act_present && p.act_code == pend_code && ts == gls_pkg::TS_IDLE;
   // A taught code is committed on redetection after the power cycle, or after a teach-in abort.
   always_ff @(posedge REF_CLK)
   begin
      if (NVM_CLR)
      begin
         stored_code <= '0;
         pend_code <= '0;
         learned <= 1'b0;
         pend_valid <= 1'b0;
         inhibit_req <= 1'b0;
      end
      else if (CE && !RST)
      begin
         if (ts == gls_pkg::TS_LEARN && tick && tt == gls_pkg::TEACH_TICKS - 15'h1)
         begin
            pend_code <= p.act_code;
            pend_valid <= 1'b1;
         end
         else if (redetect)
         begin
            inhibit_req <= learned && reteach; // [R18]
            stored_code <= pend_code; // [R15] [R17]
            learned <= 1'b1;
            pend_valid <= 1'b0;
         end
         else if (inhibit_req && inh_t == gls_pkg::INHIB_TICKS && code_ok)
            inhibit_req <= 1'b0;
      end
   end
   // The inhibit timer is volatile, so any reset restarts it from zero.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         inh_t <= '0; // [R19]
      else if (CE && inhibit_req && tick && inh_t != gls_pkg::INHIB_TICKS)
         inh_t <= inh_t + 15'h1;
   end
   assign inhibit = indiv && inhibit_req;
   assign code_ok = p.act_present && (!indiv || (learned && p.act_code == stored_code));

   // ****************************************************************
   // Teach-in sequencer
   // ****************************************************************
   logic new_pres, teach_ok, teach_start, act_bad, teaching, abort;
   assign new_pres = p.act_present && !pres_d;
   assign teach_ok = !learned || reteach; // [R16] [R17]
   assign teach_start = indiv && new_pres && first_pres && !code_ok && !pend_valid && teach_ok;
   assign act_bad = indiv && p.act_present && !code_ok && !pend_valid && ts == gls_pkg::TS_IDLE &&
                    !teach_start && !(first_pres && teach_ok); // [R16] [R25]
   assign abort = (ts == gls_pkg::TS_PWR_REQ) && tick && tt == gls_pkg::ABORT_TICKS - 15'h1;
   assign teaching = (ts != gls_pkg::TS_IDLE);
   // Only the first presentation after power-up may start a teach-in.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         pres_d <= 1'b0;
         first_pres <= 1'b1;
      end
      else if (CE)
      begin
         pres_d <= p.act_present;
         if (new_pres)
            first_pres <= 1'b0;
      end
   end
   // Teach states; TS_PWR_REQ waits for the power-down that RST represents.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         ts <= gls_pkg::TS_IDLE;
         tt <= '0;
      end
      else if (CE)
      begin
         case (ts)
            gls_pkg::TS_IDLE:
               if (teach_start)
               begin
                  ts <= gls_pkg::TS_LEARN; // [R12]
                  tt <= '0;
               end
            gls_pkg::TS_LEARN:
               if (tick)
               begin
                  tt <= (tt == gls_pkg::TEACH_TICKS - 15'h1) ? '0 : tt + 15'h1;
                  if (tt == gls_pkg::TEACH_TICKS - 15'h1)
                     ts <= gls_pkg::TS_PWR_REQ; // [R13]
               end
            gls_pkg::TS_PWR_REQ:
               if (tick)
               begin
                  tt <= tt + 15'h1;
                  if (abort)
                     ts <= gls_pkg::TS_IDLE; // [R14]
               end
            default:
               ts <= gls_pkg::TS_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Fault handling
   // ****************************************************************
   logic warn, err, lockout, door_d, diag_rst_d;
   logic [2:0] warn_code, err_code, seen;
   logic [14:0] wt;
   logic warn_cause, any_cause, clear_req, wt_done;
   assign warn_cause = p.flt_out_a || p.flt_out_b || p.flt_xshort || p.flt_temp;
   assign any_cause = warn_cause || p.knob_mid || p.flt_internal || act_bad;
   always_comb
   begin
      if (p.flt_xshort || (p.flt_out_a && p.flt_out_b))
         warn_code = gls_pkg::FC_XSHORT;
      else if (p.flt_out_a)
         warn_code = gls_pkg::FC_OUT_A;
      else if (p.flt_out_b)
         warn_code = gls_pkg::FC_OUT_B;
      else if (p.flt_temp)
         warn_code = gls_pkg::FC_TEMP;
      else
         warn_code = gls_pkg::FC_NONE;
   end
   assign wt_done = warn && tick && wt == gls_pkg::WARN_TICKS - 15'h1;
   // Opening the guard or a falling serial reset bit clears, once the cause is gone.
   assign clear_req = !any_cause && ((door_d && !p.door_closed) || (diag_rst_d && !p.diag_rst_req)); // [R06] [R07] [R08]
   // Warning starts only while outputs are on; the timer clears with the warning.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         warn <= 1'b0;
         wt <= '0;
         door_d <= 1'b0;
         diag_rst_d <= 1'b0;
      end
      else if (CE)
      begin
         door_d <= p.door_closed;
         diag_rst_d <= p.diag_rst_req;
         warn <= warn_cause && !err && !wt_done && (warn || SAFETY_OUTPUT_A); // [R05] [R11]
         wt <= (warn && warn_cause && !wt_done) ? wt + 15'(tick) : '0; // [R26]
      end
   end
   // Latched error; a new cause wins over a clear in the same cycle.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         err <= 1'b0;
         err_code <= gls_pkg::FC_NONE;
         seen <= '0;
         lockout <= 1'b0;
      end
      else if (CE)
      begin
         if (p.flt_internal)
         begin
            err <= 1'b1; // [R10]
            err_code <= gls_pkg::FC_INTERNAL;
         end
         else if (p.knob_mid)
         begin
            err <= 1'b1; // [R20]
            err_code <= gls_pkg::FC_KNOB;
         end
         else if (act_bad || abort)
         begin
            err <= 1'b1; // [R14] [R25]
            err_code <= gls_pkg::FC_ACT;
         end
         else if (wt_done || (warn_cause && !warn && !SAFETY_OUTPUT_A && !err))
         begin
            err <= 1'b1; // [R05]
            err_code <= warn_code;
         end
         else if (clear_req)
         begin
            err <= 1'b0;
            err_code <= gls_pkg::FC_NONE;
         end
         if (p.flt_out_a)
            seen[0] <= 1'b1;
         if (p.flt_out_b)
            seen[1] <= 1'b1;
         if (p.flt_xshort)
            seen[2] <= 1'b1;
         if ((seen & (seen - 3'h1)) != 3'h0)
            lockout <= 1'b1; // [R09]
      end
   end

   // ****************************************************************
   // Output decisions
   // ****************************************************************
   logic lock_req, door_ok, locked, enable, stop;
   logic [2:0] red_code;
   assign lock_req = unlock_var ? !p.lock_cmd : p.lock_cmd;
   assign door_ok = p.door_closed && code_ok;
   assign locked = door_ok && p.bolt_in;
   assign stop = err || lockout || teaching || inhibit || p.flt_internal; // [R10] [R12] [R18]
   assign enable = !stop && (lock_mon ? locked : door_ok); // [R03] [R04] [R22] [R23]
   assign red_code = lockout ? gls_pkg::FC_INTERNAL : (err ? err_code : warn_code);
   // Outputs are registered so that they stay glitch free toward the monitor.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         MAGNET_ON <= 1'b0;
         SAFETY_OUTPUT_A <= 1'b0;
         SAFETY_OUTPUT_B <= 1'b0;
         DIAG_OUT <= 1'b0;
         LED_GREEN <= 1'b0;
         LED_RED <= 1'b0;
         LED_YELLOW <= 1'b0;
      end
      else if (CE)
      begin
         MAGNET_ON <= unlock_var ? !(lock_req && !p.knob_mid) : (lock_req && !p.knob_mid); // [R01] [R02] [R20]
         SAFETY_OUTPUT_A <= enable;
         SAFETY_OUTPUT_B <= enable;
         DIAG_OUT <= !stop && !warn && door_ok && (locked || !lock_req); // [R05] [R21] [R22] [R23]
         LED_GREEN <= !teaching && (!inhibit || flash1); // [R12] [R18]
         if (teaching)
            LED_RED <= 1'b1; // [R12]
         else if (red_code == gls_pkg::FC_INTERNAL)
            LED_RED <= 1'b1; // [R25]
         else
            LED_RED <= (err || warn) && !slot[0] && slot[3:1] < red_code; // [R24] [R25]
         if (ts == gls_pkg::TS_LEARN)
            LED_YELLOW <= flash1; // [R12]
         else if (ts == gls_pkg::TS_PWR_REQ)
            LED_YELLOW <= flash3; // [R13]
         else
            LED_YELLOW <= !err && !warn && !stop && (locked || (door_ok && flash1)); // [R21] [R22]
      end
   end

   // ****************************************************************
   // APB read data
   // ****************************************************************
   // Read data is captured in the setup cycle so the access answers at once.
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         PRDATA <= '0;
      else if (CE && rd_setup)
      begin
         case (PADDR)
            gls_pkg::OFS_CTRL: PRDATA <= {28'h0, ctrl};
            gls_pkg::OFS_STATUS: PRDATA <= {20'h0, 1'b0, red_code, inhibit, teaching, lockout, err, warn,
                                            locked, door_ok, SAFETY_OUTPUT_A};
            gls_pkg::OFS_CODE: PRDATA <= {22'h0, pend_valid, learned, stored_code};
            default: PRDATA <= '0;
         endcase
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   teach_outs_a: assert property (@(posedge REF_CLK) disable iff (RST)
      CE && teaching |=> !SAFETY_OUTPUT_A && !SAFETY_OUTPUT_B && !DIAG_OUT) else $error("outputs on in teach"); // [R12]
   teach_leds_a: assert property (@(posedge REF_CLK) disable iff (RST)
      CE && ts == gls_pkg::TS_LEARN |=> !LED_GREEN && LED_RED) else $error("teach LEDs wrong"); // [R12]
   internal_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
      CE && p.flt_internal ##1 CE |=> err && err_code == gls_pkg::FC_INTERNAL && !SAFETY_OUTPUT_A)
      else $error("internal fault kept outputs"); // [R10]
   warn_timeout_a: assert property (@(posedge REF_CLK) disable iff (RST)
      CE && wt_done && !p.flt_internal && !p.knob_mid && !act_bad && !abort |=> err)
      else $error("warning did not time out"); // [R05]
   warn_clear_a: assert property (@(posedge REF_CLK) disable iff (RST)
      CE && !warn_cause |=> !warn && wt == 15'h0) else $error("warning stuck"); // [R11]
   lockout_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
      lockout |=> lockout && !SAFETY_OUTPUT_A) else $error("lockout released"); // [R09]
   magnet_unl_a: assert property (@(posedge REF_CLK) disable iff (RST)
      CE && unlock_var && p.lock_cmd |=> MAGNET_ON) else $error("unlock magnet off"); // [R01]
   magnet_lck_a: assert property (@(posedge REF_CLK) disable iff (RST)
      CE && !unlock_var && p.lock_cmd && !p.knob_mid |=> MAGNET_ON) else $error("lock magnet off"); // [R02]
   knob_fault_a: assert property (@(posedge REF_CLK) disable iff (RST)
      CE && p.knob_mid && !p.flt_internal |=> err && err_code == gls_pkg::FC_KNOB)
      else $error("knob fault missed"); // [R20]
   door_open_a: assert property (@(posedge REF_CLK) disable iff (RST)
      CE && !p.door_closed |=> !SAFETY_OUTPUT_A && !SAFETY_OUTPUT_B && !DIAG_OUT)
      else $error("outputs on with guard open"); // [R23]
   cov_warn_c: cover property (@(posedge REF_CLK) warn && SAFETY_OUTPUT_A && !DIAG_OUT);
   cov_teach_c: cover property (@(posedge REF_CLK) ts == gls_pkg::TS_PWR_REQ);
   cov_relock_c: cover property (@(posedge REF_CLK) !SAFETY_OUTPUT_A ##1 SAFETY_OUTPUT_A && p.door_closed);
   cov_clear_c: cover property (@(posedge REF_CLK) err ##1 !err);

endmodule // gls_ctrl

// [testbench/gls_partner.sv]
// Bolt mechanics behind the magnet drive, seen from the guard side.
// Assumes the bench gives the door state, variant bit and bolt latency.
module gls_partner (
   // Clock
   input wire logic clk,
   // Guard and drive
   input wire logic door,
   input wire logic magnet,
   input wire logic unlock_var,
   input wire logic [3:0] lat,
   // Bolt sense
   output logic bolt = 1'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // The bolt lands only after lat cycles, so a slow latch is exercised too.
   always @(posedge clk)
   begin
      if (door && (unlock_var ? !magnet : magnet))
         cnt <= (cnt < lat) ? cnt + 1 : cnt;
      else
         cnt <= 0;
      bolt <= door && (cnt >= lat);
   end
endmodule // gls_partner

// [testbench/guard_lock_safety_controller_tb_top.sv]
// Self-checking bench for the guard-lock controller against a behavioural model.
// Assumes zero-wait APB and a prescaler shortened to four cycles a tick.
module guard_lock_safety_controller_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, nvm = 1, cmd = 0, door = 0, knob = 0, act = 0, sdr = 0;
   logic psel = 0, pen = 0, pwr = 0, bolt, mag, sa, sb, dg, lg, lr, ly, rdy, serr, e;
   logic [4:0] flt = 0;
   logic [7:0] code = 0, paddr = 0;
   logic [31:0] pwd = 0, prd, q;
   logic [3:0] lat = 1;
   int err_total = 0, tests_run = 0, uv = 0, lm = 1, warn = 0, erl = 0;
   // Clock at 20 MHz.
   always #25 clk = ~clk;
   gls_ctrl #(.TICK_CYC(4)) uut (.REF_CLK(clk), .RST(rst), .CE(1'h1), .NVM_CLR(nvm),
      .LOCK_CMD(cmd), .DOOR_CLOSED(door), .BOLT_IN(bolt), .KNOB_MID(knob), .ACT_PRESENT(act),
      .ACT_CODE(code), .FLT_OUT_A(flt[0]), .FLT_OUT_B(flt[1]), .FLT_XSHORT(flt[2]),
      .FLT_TEMP(flt[3]), .FLT_INTERNAL(flt[4]), .SERIAL_DIAG_LINK_RESET(sdr), .MAGNET_ON(mag),
      .SAFETY_OUTPUT_A(sa), .SAFETY_OUTPUT_B(sb), .DIAG_OUT(dg), .LED_GREEN(lg), .LED_RED(lr),
      .LED_YELLOW(ly), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd),
      .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr));
   gls_partner mech (.clk(clk), .door(door), .magnet(mag), .unlock_var(uv[0]), .lat(lat), .bolt(bolt));
   // Comparison and the single closing point.
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      tests_run++;
      if (s !== x)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One APB transfer; the request holds until pready is seen high, for at most 20 cycles.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'h1;
      pen <= 1'h0;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (rdy === 1'h1)
            break;
      end
      if (i == 20)
         chk("pready wait", 0, 1);
      q = prd;
      e = serr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   // Expected magnet, outputs, diagnostic and green from the model state.
   function automatic logic [4:0] model();
      logic lk, sf;
      lk = door && (uv ? !cmd : cmd);
      sf = door && !erl && (lm ? lk : 1'h1);
      return {cmd, sf, sf, door && !erl && !warn, 1'h1};
   endfunction
   // Outputs trail pins and the bolt, so allow a bounded settling time.
   // A fixed lead-in keeps stale outputs from matching before the pins have acted.
   // Outputs are looked at on the falling edge, where they are settled.
   task automatic settle(input string n);
      int i;
      repeat (8) @(negedge clk);
      for (i = 0; i < 80 && {mag, sa, sb, dg, lg} !== model(); i++)
         @(negedge clk);
      chk(n, {mag, sa, sb, dg, lg}, model());
      @(posedge clk);
   endtask
   // Hang guard.
   initial
   begin
      #2ms;
      err_total++;
      conclude();
   end
   // Main sequence.
   initial
   begin
      void'($urandom(97));
      code <= 8'($urandom);
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      nvm <= 1'h0;
      act <= 1'h1;
      apb(0, gls_pkg::OFS_CTRL, 0);
      chk("ctrl reset", q, 32'h2);
      apb(1, 8'h40, $urandom);
      chk("unmapped error", e, 1);
      door <= 1'h1;
      cmd <= 1'h1;
      settle("closed locked");
      chk("leds locked", {lr, ly}, 2'h1);
      cmd <= 1'h0;
      settle("unlocked");
      lat <= 4'($urandom_range(2, 9));
      cmd <= 1'h1;
      settle("relocked");
      // A warning keeps the outputs on and names its cause in the red code.
      for (int i = 0; i < 4; i += 3)
      begin
         flt <= 5'(1 << i);
         warn = 1;
         settle("warning");
         apb(0, gls_pkg::OFS_STATUS, 0);
         chk("warn code", {q[10:8], q[3]}, (i == 3) ? 4'h9 : 4'h3);
         flt <= 5'h0;
         warn = 0;
         settle("warning gone");
      end
      flt <= 5'h10;
      erl = 1;
      settle("internal");
      chk("red steady", lr, 1);
      flt <= 5'h0;
      repeat ($urandom_range(4, 9)) @(posedge clk);
      settle("still latched");
      sdr <= 1'h1;
      repeat (4) @(posedge clk);
      sdr <= 1'h0;
      erl = 0;
      settle("serial clear");
      knob <= 1'h1;
      repeat (12) @(posedge clk);
      chk("knob hold", {mag, sa}, 2'h0);
      apb(0, gls_pkg::OFS_STATUS, 0);
      chk("knob code", q[10:8], 3'h6);
      knob <= 1'h0;
      door <= 1'h0;
      settle("door open");
      chk("leds open", {lr, ly}, 2'h0);
      apb(0, gls_pkg::OFS_STATUS, 0);
      chk("error bit", q[4], 0);
      apb(1, gls_pkg::OFS_CTRL, 32'h1);
      uv = 1;
      lm = 0;
      door <= 1'h1;
      cmd <= 1'h0;
      settle("unlock variant locked");
      cmd <= 1'h1;
      settle("door monitored release");
      // A second output fault after the first locks the guard out until power is cycled.
      flt <= 5'h2;
      erl = 1;
      settle("second output fault");
      flt <= 5'h0;
      apb(0, gls_pkg::OFS_STATUS, 0);
      chk("lockout", {q[10:8], q[5]}, 4'hF);
      // Power cycle, then teach a new actuator on an individually coded guard.
      act <= 1'h0;
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      apb(1, gls_pkg::OFS_CTRL, 32'h4);
      act <= 1'h1;
      repeat (12) @(posedge clk);
      chk("teach leds", {lg, lr, sa, dg}, 4'h4);
      repeat (520) @(posedge clk);
      apb(0, gls_pkg::OFS_CODE, 0);
      chk("teach pending", q[9:8], 2'h2);
      // The taught code is committed only when seen again after the power cycle.
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      repeat (8) @(posedge clk);
      apb(0, gls_pkg::OFS_CODE, 0);
      chk("taught code", q, {22'h0, 2'h1, code});
      conclude();
   end
endmodule // guard_lock_safety_controller_tb_top
